// File: rtl/emif_bank_pkg.sv
// Constants shared by the interrupt-mask and NAND parity register bank.
// Assumes a byte-addressed register port with 32-bit aligned words.
package emif_bank_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int XFER_W = 16;
  localparam int WAIT_CNT_W = 8;
  localparam int PAR_TERMS = 12;
  localparam int ROW_IDX_W = 9;

  localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE_SET = 8'h48;
  localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE_CLEAR = 8'h4c;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h50;
  localparam logic [ADDR_W-1:0] OFF_WAIT_CONFIG = 8'h54;
  localparam logic [ADDR_W-1:0] OFF_NAND_CONTROL = 8'h60;
  localparam logic [ADDR_W-1:0] OFF_NAND_STATUS = 8'h64;
  localparam logic [ADDR_W-1:0] OFF_NAND_PARITY_CODE = 8'h70;

  // Bit positions
  localparam int BIT_TIMEOUT_EN = 0;
  localparam int BIT_WAIT_RISE_EN = 2;
  localparam int BIT_TIMEOUT_RAW = 0;
  localparam int BIT_WAIT_RISE_RAW = 2;
  localparam int BIT_TIMEOUT_MASKED = 16;
  localparam int BIT_WAIT_RISE_MASKED = 18;
  localparam int BIT_NAND_MODE = 0;
  localparam int BIT_PARITY_START = 8;
  localparam int BIT_WAIT_LEVEL = 0;
  localparam int BIT_WAIT_POLARITY = 8;
  localparam int MAX_WAIT_LSB = 0;
  localparam int PAR_EVEN_LSB = 0;
  localparam int PAR_ODD_LSB = 16;

  localparam int COLS_BYTE = 3;
  localparam int COLS_HALF = 4;
  localparam int WIDTH_BYTE = 8;
  localparam int WIDTH_HALF = 16;

  localparam logic [WAIT_CNT_W-1:0] MAX_WAIT_RESET = 8'h80;
  localparam logic WAIT_POLARITY_RESET = 1'b1;
  localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;
endpackage

// File: rtl/bank_core_if.sv
// Carrier between the register bank and its wait monitor and parity engine.
// Assumes all parties run on the one bank clock.
`timescale 1ns/1ps
interface bank_core_if;
  import emif_bank_pkg::*;
  logic wait_level;
  logic wait_polarity;
  logic [WAIT_CNT_W-1:0] max_wait;
  logic access_active;
  logic timeout_pulse;
  logic rise_pulse;
  logic par_clear;
  logic par_valid;
  logic par_half;
  logic [XFER_W-1:0] par_data;
  logic [PAR_TERMS-1:0] par_odd;
  logic [PAR_TERMS-1:0] par_even;

  modport bank (output wait_level, wait_polarity, max_wait, access_active, par_clear,
    par_valid, par_half, par_data, input timeout_pulse, rise_pulse, par_odd, par_even);
  modport wait_mon (input wait_level, wait_polarity, max_wait, access_active,
    output timeout_pulse, rise_pulse);
  modport parity (input par_clear, par_valid, par_half, par_data, output par_odd, par_even);
endinterface

// File: rtl/wait_monitor.sv
// Wait pin rising-edge detector and asynchronous access timeout counter.
// Assumes the wait level is already synchronous to the bank clock.
`timescale 1ns/1ps
module wait_monitor
  import emif_bank_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  bank_core_if.wait_mon core
);
  logic wait_prev_q;
  logic [WAIT_CNT_W-1:0] cnt_q;
  logic fired_q;
  logic rise_q;
  logic tmo_q;
  logic wait_asserted;
  logic cnt_hit;

  assign wait_asserted = (core.wait_level == core.wait_polarity);
  assign cnt_hit = (cnt_q >= core.max_wait);
  assign core.rise_pulse = rise_q;
  assign core.timeout_pulse = tmo_q;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wait_prev_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      wait_prev_q <= core.wait_level;
      rise_q <= core.wait_level & ~wait_prev_q;
    end
  end

  // One timeout per stalled access; count restarts when wait drops
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= '0;
      fired_q <= 1'b0;
      tmo_q <= 1'b0;
    end else if (!core.access_active || !wait_asserted) begin
      cnt_q <= '0;
      fired_q <= 1'b0;
      tmo_q <= 1'b0;
    end else begin
      cnt_q <= cnt_hit ? cnt_q : cnt_q + 1'b1;
      fired_q <= fired_q | cnt_hit;
      tmo_q <= cnt_hit & ~fired_q;
    end
  end
endmodule

// File: rtl/nand_parity_calc.sv
// Row and column parity accumulator for NAND page data.
// Assumes one transfer per valid cycle; 8-bit mode uses the low data byte.
`timescale 1ns/1ps
module nand_parity_calc
  import emif_bank_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  bank_core_if.parity core
);
  logic [PAR_TERMS-1:0] odd_q;
  logic [PAR_TERMS-1:0] odd_d;
  logic [PAR_TERMS-1:0] even_q;
  logic [PAR_TERMS-1:0] even_d;
  logic [ROW_IDX_W-1:0] idx_q;
  logic [XFER_W-1:0] data_eff;
  logic row_par;
  int cols;
  int width;

  assign cols = core.par_half ? COLS_HALF : COLS_BYTE;
  assign width = core.par_half ? WIDTH_HALF : WIDTH_BYTE;
  assign data_eff = core.par_half ? core.par_data : {8'h00, core.par_data[7:0]};
  assign row_par = ^data_eff;
  assign core.par_odd = odd_q;
  assign core.par_even = even_q;

  always_comb begin
    odd_d = odd_q;
    even_d = even_q;
    if (core.par_clear) begin
      odd_d = '0;
      even_d = '0;
    end else if (core.par_valid) begin
      for (int t = 0; t < PAR_TERMS; t++) begin
        if (t < cols) begin
          for (int i = 0; i < XFER_W; i++) begin
            if (i < width) begin
              if (i[t]) odd_d[t] = odd_d[t] ^ data_eff[i];
              else even_d[t] = even_d[t] ^ data_eff[i];
            end
          end
        end else if (idx_q[t-cols]) begin
          odd_d[t] = odd_d[t] ^ row_par;
        end else begin
          even_d[t] = even_d[t] ^ row_par;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      odd_q <= '0;
      even_q <= '0;
      idx_q <= '0;
    end else begin
      odd_q <= odd_d;
      even_q <= even_d;
      if (core.par_clear) idx_q <= '0;
      else if (core.par_valid) idx_q <= idx_q + 1'b1;
    end
  end
endmodule

// File: rtl/emif_irq_mask_nand_ecc_regs.sv
// Interrupt enable set/clear bank, NAND control, wait status and parity code.
// Assumes a single-cycle strobe register port and synchronous pin inputs.
//
// Functional notes
// - Timeout set bit writes 1, enables both mirrors
// - Masked timeout flag zero unless enabled
// - Writing zeros to enable bits changes nothing
// - Wait-rise set bit enables; only clear disables
// - Wait-rise clear bit disables both mirrors
// - Timeout clear bit disables both mirrors
// - Set and clear registers read enable state
// - Without wait pin, enable registers reserved
// - Reserved bits read zero, software writes zero
// - NAND mode bit selects NAND on CS2
// - Parity start bit starts parity calculation
// - Status bit0 shows raw wait pin level
// - Parity code: odd high, even low field
// - 8-bit: P1-P6 column, rest row parities
// - 16-bit: P1-P8 column, rest row parities
// - Timeout when wait exceeds configured maximum
// - Wait rise raw set on rising edge
// - Pulse interrupt when masked flag becomes set
`timescale 1ns/1ps
module emif_irq_mask_nand_ecc_regs
  import emif_bank_pkg::*;
#(
  parameter bit HAS_WAIT_PIN = 1'b1
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  input wire logic ext_wait_in_i,
  input wire logic ext_access_active_i,
  input wire logic chip_select_two_i,
  input wire logic nand_xfer_valid_i,
  input wire logic [XFER_W-1:0] nand_xfer_data_i,
  input wire logic nand_bus16_i,
  output logic irq_o,
  output logic nand_mode_sel_o,
  output logic parity_calc_start_o
);
  bank_core_if core ();

  logic timeout_en_q;
  logic wait_rise_en_q;
  logic timeout_raw_q;
  logic wait_rise_raw_q;
  logic timeout_masked_q;
  logic wait_rise_masked_q;
  logic nand_mode_q;
  logic parity_start_q;
  logic wait_polarity_q;
  logic [WAIT_CNT_W-1:0] max_wait_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic irq_q;

  // Address decode
  logic hit_set;
  logic hit_clear;
  logic hit_status;
  logic hit_wait_cfg;
  logic hit_nand_ctl;
  logic hit_nand_stat;
  logic hit_parity;
  logic wr_set;
  logic wr_clear;
  logic wr_status;
  logic wr_wait_cfg;
  logic wr_nand_ctl;

  assign hit_set = (reg_addr_i == OFF_IRQ_ENABLE_SET);
  assign hit_clear = (reg_addr_i == OFF_IRQ_ENABLE_CLEAR);
  assign hit_status = (reg_addr_i == OFF_IRQ_STATUS);
  assign hit_wait_cfg = (reg_addr_i == OFF_WAIT_CONFIG);
  assign hit_nand_ctl = (reg_addr_i == OFF_NAND_CONTROL);
  assign hit_nand_stat = (reg_addr_i == OFF_NAND_STATUS);
  assign hit_parity = (reg_addr_i == OFF_NAND_PARITY_CODE);

  // Enable registers vanish entirely on parts without the wait pin
  assign wr_set = reg_wr_i & hit_set & HAS_WAIT_PIN;
  assign wr_clear = reg_wr_i & hit_clear & HAS_WAIT_PIN;
  assign wr_status = reg_wr_i & hit_status & HAS_WAIT_PIN;
  assign wr_wait_cfg = reg_wr_i & hit_wait_cfg;
  assign wr_nand_ctl = reg_wr_i & hit_nand_ctl;

  // Enable control decode
  logic tmo_en_set;
  logic tmo_en_clr;
  logic rise_en_set;
  logic rise_en_clr;

  assign tmo_en_set = wr_set & reg_wdata_i[BIT_TIMEOUT_EN];
  assign tmo_en_clr = wr_clear & reg_wdata_i[BIT_TIMEOUT_EN];
  assign rise_en_set = wr_set & reg_wdata_i[BIT_WAIT_RISE_EN];
  assign rise_en_clr = wr_clear & reg_wdata_i[BIT_WAIT_RISE_EN];

  // Status clear decode, either raw or masked bit clears the pair
  logic tmo_flag_clr;
  logic rise_flag_clr;

  assign tmo_flag_clr = wr_status &
    (reg_wdata_i[BIT_TIMEOUT_RAW] | reg_wdata_i[BIT_TIMEOUT_MASKED]);
  assign rise_flag_clr = wr_status &
    (reg_wdata_i[BIT_WAIT_RISE_RAW] | reg_wdata_i[BIT_WAIT_RISE_MASKED]);

  // Events from the wait monitor
  logic tmo_evt;
  logic rise_evt;
  logic tmo_masked_evt;
  logic rise_masked_evt;

  assign tmo_evt = core.timeout_pulse & HAS_WAIT_PIN;
  assign rise_evt = core.rise_pulse & HAS_WAIT_PIN;
  assign tmo_masked_evt = tmo_evt & timeout_en_q;
  assign rise_masked_evt = rise_evt & wait_rise_en_q;

  // Sub-block connections
  // Pin is taken as already synchronous; no flops spent ahead of the monitor
  assign core.wait_level = ext_wait_in_i;
  assign core.wait_polarity = wait_polarity_q;
  assign core.max_wait = max_wait_q;
  assign core.access_active = ext_access_active_i;
  assign core.par_clear = wr_nand_ctl & reg_wdata_i[BIT_PARITY_START];
  assign core.par_valid = nand_xfer_valid_i & chip_select_two_i & nand_mode_q &
    parity_start_q & ~core.par_clear;
  assign core.par_half = nand_bus16_i;
  assign core.par_data = nand_xfer_data_i;

  wait_monitor u_wait_monitor (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .core(core.wait_mon)
  );

  nand_parity_calc u_nand_parity_calc (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .core(core.parity)
  );

  // Read views
  logic [DATA_W-1:0] enable_view;
  logic [DATA_W-1:0] status_view;
  logic [DATA_W-1:0] wait_cfg_view;
  logic [DATA_W-1:0] nand_ctl_view;
  logic [DATA_W-1:0] nand_stat_view;
  logic [DATA_W-1:0] parity_view;

  always_comb begin
    enable_view = READ_ZERO;
    enable_view[BIT_TIMEOUT_EN] = timeout_en_q;
    enable_view[BIT_WAIT_RISE_EN] = wait_rise_en_q;
  end

  always_comb begin
    status_view = READ_ZERO;
    status_view[BIT_TIMEOUT_RAW] = timeout_raw_q;
    status_view[BIT_WAIT_RISE_RAW] = wait_rise_raw_q;
    // Gated on read too, so disabling hides a pending masked flag
    status_view[BIT_TIMEOUT_MASKED] = timeout_masked_q & timeout_en_q;
    status_view[BIT_WAIT_RISE_MASKED] = wait_rise_masked_q & wait_rise_en_q;
  end

  always_comb begin
    wait_cfg_view = READ_ZERO;
    wait_cfg_view[MAX_WAIT_LSB +: WAIT_CNT_W] = max_wait_q;
    wait_cfg_view[BIT_WAIT_POLARITY] = wait_polarity_q;
  end

  always_comb begin
    nand_ctl_view = READ_ZERO;
    nand_ctl_view[BIT_NAND_MODE] = nand_mode_q;
    nand_ctl_view[BIT_PARITY_START] = parity_start_q;
  end

  always_comb begin
    nand_stat_view = READ_ZERO;
    nand_stat_view[BIT_WAIT_LEVEL] = ext_wait_in_i;
  end

  always_comb begin
    parity_view = READ_ZERO;
    parity_view[PAR_ODD_LSB +: PAR_TERMS] = core.par_odd;
    parity_view[PAR_EVEN_LSB +: PAR_TERMS] = core.par_even;
  end

  logic [DATA_W-1:0] enable_read;
  logic [DATA_W-1:0] status_read;

  assign enable_read = HAS_WAIT_PIN ? enable_view : READ_ZERO;
  assign status_read = HAS_WAIT_PIN ? status_view : READ_ZERO;

  // Selects are one-hot, so an idle or unmapped cycle reads back zero
  logic sel_enable;
  logic sel_status;
  logic sel_wait_cfg;
  logic sel_nand_ctl;
  logic sel_nand_stat;
  logic sel_parity;

  assign sel_enable = reg_rd_i & (hit_set | hit_clear);
  assign sel_status = reg_rd_i & hit_status;
  assign sel_wait_cfg = reg_rd_i & hit_wait_cfg;
  assign sel_nand_ctl = reg_rd_i & hit_nand_ctl;
  assign sel_nand_stat = reg_rd_i & hit_nand_stat;
  assign sel_parity = reg_rd_i & hit_parity;

  assign rdata_d = ({DATA_W{sel_enable}} & enable_read) |
    ({DATA_W{sel_status}} & status_read) |
    ({DATA_W{sel_wait_cfg}} & wait_cfg_view) |
    ({DATA_W{sel_nand_ctl}} & nand_ctl_view) |
    ({DATA_W{sel_nand_stat}} & nand_stat_view) |
    ({DATA_W{sel_parity}} & parity_view);

  // Enable state, one bit each, mirrored by both registers
  logic timeout_en_d;
  logic wait_rise_en_d;

  // Set and clear sit at different addresses, so they never meet in one cycle
  assign timeout_en_d = tmo_en_set | (timeout_en_q & ~tmo_en_clr);
  assign wait_rise_en_d = rise_en_set | (wait_rise_en_q & ~rise_en_clr);

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      timeout_en_q <= 1'b0;
      wait_rise_en_q <= 1'b0;
    end else begin
      timeout_en_q <= timeout_en_d;
      wait_rise_en_q <= wait_rise_en_d;
    end
  end

  // Sticky flags: a new event beats a same-cycle clear, so no event is lost
  logic timeout_raw_d;
  logic wait_rise_raw_d;
  logic timeout_masked_d;
  logic wait_rise_masked_d;

  assign timeout_raw_d = tmo_evt | (timeout_raw_q & ~tmo_flag_clr);
  assign wait_rise_raw_d = rise_evt | (wait_rise_raw_q & ~rise_flag_clr);
  assign timeout_masked_d = tmo_masked_evt | (timeout_masked_q & ~tmo_flag_clr);
  assign wait_rise_masked_d = rise_masked_evt | (wait_rise_masked_q & ~rise_flag_clr);

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      timeout_raw_q <= 1'b0;
      wait_rise_raw_q <= 1'b0;
      timeout_masked_q <= 1'b0;
      wait_rise_masked_q <= 1'b0;
    end else begin
      timeout_raw_q <= timeout_raw_d;
      wait_rise_raw_q <= wait_rise_raw_d;
      timeout_masked_q <= timeout_masked_d;
      wait_rise_masked_q <= wait_rise_masked_d;
    end
  end

  // Pulse per new masked event; held flags give no repeats
  logic irq_d;

  assign irq_d = tmo_masked_evt | rise_masked_evt;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) irq_q <= 1'b0;
    else irq_q <= irq_d;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      nand_mode_q <= 1'b0;
      parity_start_q <= 1'b0;
    end else if (wr_nand_ctl) begin
      nand_mode_q <= reg_wdata_i[BIT_NAND_MODE];
      parity_start_q <= reg_wdata_i[BIT_PARITY_START];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      max_wait_q <= MAX_WAIT_RESET;
      wait_polarity_q <= WAIT_POLARITY_RESET;
    end else if (wr_wait_cfg) begin
      max_wait_q <= reg_wdata_i[MAX_WAIT_LSB +: WAIT_CNT_W];
      wait_polarity_q <= reg_wdata_i[BIT_WAIT_POLARITY];
    end
  end

  // Registered so read data stands exactly one cycle after the strobe
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) rdata_q <= READ_ZERO;
    else rdata_q <= rdata_d;
  end

  assign reg_rdata_o = rdata_q;
  assign irq_o = irq_q;
  assign nand_mode_sel_o = nand_mode_q;
  assign parity_calc_start_o = parity_start_q;
endmodule

// File: test/emif_irq_mask_nand_ecc_regs_asserts.sv
// Concurrent checks for the interrupt-enable and NAND parity register bank.
// Assumes it is bound to the bank top and sees only its ports.
`timescale 1ns/1ps
module emif_regs_asserts
  import emif_bank_pkg::*;
#(
  parameter bit HAS_WAIT_PIN = 1'b1
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [DATA_W-1:0] reg_rdata_o,
  input wire logic ext_wait_in_i,
  input wire logic ext_access_active_i,
  input wire logic chip_select_two_i,
  input wire logic nand_xfer_valid_i,
  input wire logic [XFER_W-1:0] nand_xfer_data_i,
  input wire logic nand_bus16_i,
  input wire logic irq_o,
  input wire logic nand_mode_sel_o,
  input wire logic parity_calc_start_o
);
  logic [2:0] en_q;
  wire set_wr = reg_wr_i && reg_addr_i == OFF_IRQ_ENABLE_SET;
  wire clr_wr = reg_wr_i && reg_addr_i == OFF_IRQ_ENABLE_CLEAR;
  wire ctl_wr = reg_wr_i && reg_addr_i == OFF_NAND_CONTROL;
  wire en_rd = reg_rd_i && (reg_addr_i == OFF_IRQ_ENABLE_SET
    || reg_addr_i == OFF_IRQ_ENABLE_CLEAR);
  wire mapped = reg_addr_i inside {OFF_IRQ_ENABLE_SET, OFF_IRQ_ENABLE_CLEAR, OFF_IRQ_STATUS,
    OFF_WAIT_CONFIG, OFF_NAND_CONTROL, OFF_NAND_STATUS, OFF_NAND_PARITY_CODE};

  // Shadow of the enable state; one bit serves both mirrors
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      en_q <= 3'h0;
    end else if (HAS_WAIT_PIN && set_wr) begin
      en_q <= en_q | (reg_wdata_i[2:0] & 3'h5);
    end else if (HAS_WAIT_PIN && clr_wr) begin
      en_q <= en_q & ~(reg_wdata_i[2:0] & 3'h5);
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  // Access running would let a timeout pulse land beside the rise pulse
  sequence wait_rose_s;
    $rose(ext_wait_in_i) && en_q[2] && !set_wr && !clr_wr && !ext_access_active_i;
  endsequence
  sequence irq_pulse_s;
    irq_o ##1 !irq_o;
  endsequence
  sequence parity_clear_s;
    ctl_wr && reg_wdata_i[BIT_PARITY_START] && !nand_xfer_valid_i
    ##1 reg_rd_i && reg_addr_i == OFF_NAND_PARITY_CODE && !nand_xfer_valid_i;
  endsequence

  enable_read_a: assert property (en_rd |=> reg_rdata_o == {29'h0, $past(en_q)})
    else $error("enable readback differs from enable state");
  reserved_zero_a: assert property (reg_rd_i && !mapped |=> reg_rdata_o == READ_ZERO)
    else $error("unmapped read returned nonzero");
  mode_write_a: assert property (ctl_wr |=> nand_mode_sel_o == $past(reg_wdata_i[0]))
    else $error("nand mode output not written");
  start_write_a: assert property (ctl_wr |=> parity_calc_start_o == $past(reg_wdata_i[8]))
    else $error("parity start output not written");
  ctrl_hold_a: assert property (!ctl_wr |=> $stable({nand_mode_sel_o, parity_calc_start_o}))
    else $error("control outputs moved without a write");
  status_pin_a: assert property (reg_rd_i && reg_addr_i == OFF_NAND_STATUS
    |=> reg_rdata_o == {31'h0, $past(ext_wait_in_i)}) else $error("status bit not pin level");
  rise_irq_a: assert property (wait_rose_s |-> ##2 irq_pulse_s)
    else $error("wait rise did not pulse interrupt");
  quiet_irq_a: assert property ((en_q == 3'h0) [*3] |-> !irq_o)
    else $error("interrupt while all enables off");
  parity_clear_a: assert property (parity_clear_s |=> reg_rdata_o == READ_ZERO)
    else $error("parity code not cleared by start");
endmodule

bind emif_irq_mask_nand_ecc_regs emif_regs_asserts #(.HAS_WAIT_PIN(HAS_WAIT_PIN)) u_chk (
  .core_clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
  .ext_wait_in_i, .ext_access_active_i, .chip_select_two_i, .nand_xfer_valid_i,
  .nand_xfer_data_i, .nand_bus16_i, .irq_o, .nand_mode_sel_o, .parity_calc_start_o);

// File: test/emif_irq_mask_nand_ecc_regs_bench.sv
// Self-checking bench for the interrupt-enable and NAND parity register bank.
// Assumes the bank package and design files are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch at %0t got %h exp %h", $time, (g), (e)); end end
module emif_irq_mask_nand_ecc_regs_bench;
  import emif_bank_pkg::*;
  logic core_clk_i, rst_b_i, reg_wr_i, reg_rd_i, ext_wait_in_i, ext_access_active_i;
  logic chip_select_two_i, nand_xfer_valid_i, nand_bus16_i, irq_o;
  logic nand_mode_sel_o, parity_calc_start_o, rd_seen_q;
  logic [ADDR_W-1:0] reg_addr_i;
  logic [DATA_W-1:0] reg_wdata_i, reg_rdata_o, exp_v;
  logic [XFER_W-1:0] nand_xfer_data_i;
  logic [DATA_W-1:0] exp_q[$];
  logic [PAR_TERMS-1:0] odd_m, even_m;
  int err_total, checks_done, cycles, k_m;
  logic [DATA_W-1:0] bare_rdata;
  logic [ADDR_W-1:0] rd_addr_q;
  logic bare_irq;

  emif_irq_mask_nand_ecc_regs DUT (.core_clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .ext_wait_in_i, .ext_access_active_i,
    .chip_select_two_i, .nand_xfer_valid_i, .nand_xfer_data_i, .nand_bus16_i, .irq_o,
    .nand_mode_sel_o, .parity_calc_start_o);

  // Variant without the wait pin sees the same stimulus
  emif_irq_mask_nand_ecc_regs #(.HAS_WAIT_PIN(1'b0)) DUT_bare (.core_clk_i, .rst_b_i,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o(bare_rdata),
    .ext_wait_in_i, .ext_access_active_i, .chip_select_two_i, .nand_xfer_valid_i,
    .nand_xfer_data_i, .nand_bus16_i, .irq_o(bare_irq), .nand_mode_sel_o(),
    .parity_calc_start_o());

  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  task automatic conclude();
    $display("checks_done=%0d err_total=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge core_clk_i) begin
    if (rd_seen_q === 1'b1 && exp_q.size() > 0) begin
      exp_v = exp_q.pop_front();
      `CHK(reg_rdata_o, exp_v)
    end
    if (rd_seen_q === 1'b1 && rd_addr_q inside {OFF_IRQ_ENABLE_SET, OFF_IRQ_ENABLE_CLEAR,
        OFF_IRQ_STATUS}) begin
      `CHK(bare_rdata, READ_ZERO)
    end
    `CHK(bare_irq, 1'b0)
    rd_seen_q <= reg_rd_i;
    rd_addr_q <= reg_addr_i;
    cycles++;
    if (cycles > 2000) begin
      err_total++;
      conclude();
    end
  end

  // Every call starts just after an edge; the next call releases the strobes
  task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
    reg_wr_i <= w;
    reg_rd_i <= r;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    op(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    op(1'b0, 1'b1, a, 32'h0);
  endtask
  task automatic irq_win(input int n, input logic e);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      op(1'b0, 1'b0, 8'h00, 32'h0);
      if (irq_o === 1'b1) seen = 1'b1;
    end
    `CHK(seen, e)
  endtask

  function automatic void fold(input logic w16, input logic [15:0] d);
    int cols, n;
    logic p;
    cols = w16 ? COLS_HALF : COLS_BYTE;
    n = w16 ? WIDTH_HALF : WIDTH_BYTE;
    p = 1'b0;
    for (int i = 0; i < n; i++) begin
      p ^= d[i];
      for (int t = 0; t < cols; t++) begin
        if (i[t]) odd_m[t] ^= d[i];
        else even_m[t] ^= d[i];
      end
    end
    for (int t = cols; t < PAR_TERMS; t++) begin
      if (k_m[t - cols]) odd_m[t] ^= p;
      else even_m[t] ^= p;
    end
    k_m++;
  endfunction

  task automatic xfer(input logic w16, input logic cs, input logic keep);
    logic [15:0] d;
    d = 16'($urandom);
    nand_xfer_valid_i <= 1'b1;
    chip_select_two_i <= cs;
    nand_bus16_i <= w16;
    nand_xfer_data_i <= d;
    if (cs && keep) fold(w16, d);
    op(1'b0, 1'b0, 8'h00, 32'h0);
  endtask

  task automatic par_start(input logic w16);
    wr(OFF_NAND_CONTROL, 32'h0000_0101);
    rd(OFF_NAND_PARITY_CODE, 32'h0);
    odd_m = '0;
    even_m = '0;
    k_m = 0;
    // A deselected transfer must not fold in
    for (int i = 0; i < 6; i++) xfer(w16, i != 2, 1'b1);
    nand_xfer_valid_i <= 1'b0;
  endtask

  initial begin
    {rst_b_i, reg_wr_i, reg_rd_i, ext_wait_in_i, ext_access_active_i, rd_seen_q} = '0;
    {chip_select_two_i, nand_xfer_valid_i, nand_bus16_i} = '0;
    {reg_addr_i, reg_wdata_i, nand_xfer_data_i} = '0;
    {err_total, checks_done, cycles} = '0;
    void'($urandom(83));
    repeat (3) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    rd(OFF_IRQ_ENABLE_SET, 32'h0);
    rd(OFF_IRQ_ENABLE_CLEAR, 32'h0);
    rd(OFF_NAND_CONTROL, 32'h0);
    rd(OFF_NAND_PARITY_CODE, 32'h0);
    rd(OFF_NAND_STATUS, 32'h0);
    wr(OFF_IRQ_ENABLE_SET, 32'hffff_ffff);
    rd(OFF_IRQ_ENABLE_SET, 32'h5);
    rd(OFF_IRQ_ENABLE_CLEAR, 32'h5);
    wr(OFF_IRQ_ENABLE_SET, 32'h0);
    wr(OFF_IRQ_ENABLE_CLEAR, 32'h0);
    rd(OFF_IRQ_ENABLE_CLEAR, 32'h5);
    wr(OFF_IRQ_ENABLE_CLEAR, 32'h4);
    rd(OFF_IRQ_ENABLE_SET, 32'h1);
    wr(OFF_IRQ_ENABLE_CLEAR, 32'h1);
    rd(OFF_IRQ_ENABLE_CLEAR, 32'h0);
    wr(8'h5c, 32'hffff_ffff);
    rd(8'h5c, 32'h0);
    wr(OFF_IRQ_ENABLE_SET, 32'h4);
    ext_wait_in_i <= 1'b1;
    irq_win(6, 1'b1);
    rd(OFF_NAND_STATUS, 32'h1);
    wr(OFF_WAIT_CONFIG, 32'h0);
    rd(OFF_NAND_STATUS, 32'h1);
    rd(OFF_IRQ_STATUS, 32'h0004_0004);
    wr(OFF_IRQ_STATUS, 32'h4);
    rd(OFF_IRQ_STATUS, 32'h0);
    wr(OFF_IRQ_ENABLE_CLEAR, 32'h4);
    ext_wait_in_i <= 1'b0;
    op(1'b0, 1'b0, 8'h00, 32'h0);
    ext_wait_in_i <= 1'b1;
    irq_win(6, 1'b0);
    rd(OFF_IRQ_STATUS, 32'h4);
    wr(OFF_IRQ_STATUS, 32'h4);
    wr(OFF_WAIT_CONFIG, 32'h0000_0104);
    wr(OFF_IRQ_ENABLE_SET, 32'h1);
    ext_access_active_i <= 1'b1;
    irq_win(12, 1'b1);
    ext_access_active_i <= 1'b0;
    rd(OFF_IRQ_STATUS, 32'h0001_0001);
    wr(OFF_IRQ_STATUS, 32'h0001_0000);
    rd(OFF_IRQ_STATUS, 32'h0);
    wr(OFF_IRQ_ENABLE_CLEAR, 32'h1);
    ext_access_active_i <= 1'b1;
    irq_win(12, 1'b0);
    ext_access_active_i <= 1'b0;
    rd(OFF_IRQ_STATUS, 32'h1);
    wr(OFF_IRQ_STATUS, 32'h1);
    wr(OFF_WAIT_CONFIG, 32'h0000_0004);
    ext_access_active_i <= 1'b1;
    irq_win(12, 1'b0);
    ext_access_active_i <= 1'b0;
    rd(OFF_IRQ_STATUS, 32'h0);
    par_start(1'b0);
    `CHK(nand_mode_sel_o, 1'b1)
    `CHK(parity_calc_start_o, 1'b1)
    rd(OFF_NAND_CONTROL, 32'h0000_0101);
    rd(OFF_NAND_PARITY_CODE, {4'h0, odd_m, 4'h0, even_m});
    par_start(1'b1);
    rd(OFF_NAND_PARITY_CODE, {4'h0, odd_m, 4'h0, even_m});
    wr(OFF_NAND_CONTROL, 32'h0000_0001);
    xfer(1'b1, 1'b1, 1'b0);
    nand_xfer_valid_i <= 1'b0;
    `CHK(parity_calc_start_o, 1'b0)
    rd(OFF_NAND_PARITY_CODE, {4'h0, odd_m, 4'h0, even_m});
    wr(OFF_NAND_CONTROL, 32'h0);
    irq_win(2, 1'b0);
    `CHK(nand_mode_sel_o, 1'b0)
    conclude();
  end
endmodule
